// file: soft_trace_and_trigger_unit.sv
// Software trace buffer, trace memory and external trigger logic.
// Assumes the CPU and register file share pclk; trigger and emulator pins
// are asynchronous.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module soft_trace_and_trigger_unit import sw_trace_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire instr_t instr,
  output logic instr_ready,
  output logic [4:0] gpr_idx,
  input wire logic [31:0] gpr_val,
  input wire logic cpu_break,
  input wire logic emu_connected,
  input wire logic [1:0] trig_in,
  output logic [1:0] trig_out,
  output logic break_req,
  output logic rec_valid,
  output trace_rec_t rec_data,
  output dest_t rec_dest,
  input wire logic rec_ready,
  output logic irq
);
  logic [1:0] trig_s1_r, trig_s2_r, trig_prev_r;
  logic conn_s1_r, conn_s2_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [7:0] ctrl_r;
  logic [11:0] tcfg_r;
  logic [15:0] tw_r [TRIG_CH];
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
  logic irq_r, break_r;
  logic [5:0] ram_idx_r, ram_wp_r;
  logic ram_stop_r, ram_wrap_r;
  trace_rec_t ram_mem [RAM_DEPTH];
  trace_rec_t buf_mem [BUF_DEPTH];
  logic [2:0] wp_r, rp_r;
  logic [3:0] cnt_r;
  seq_t state_r, state_nxt;
  instr_t cur_r;
  logic [4:0] idx_r;
  logic ready_r;
  logic rec_valid_r;
  trace_rec_t rec_data_r;
  dest_t rec_dest_r;
  logic [1:0] trig_det, trig_brk, trig_stop, trig_out_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_r <= 2'h0;
      trig_s2_r <= 2'h0;
      trig_prev_r <= 2'h0;
      conn_s1_r <= 1'b0;
      conn_s2_r <= 1'b0;
    end else begin
      trig_s1_r <= trig_in;
      trig_s2_r <= trig_s1_r;
      trig_prev_r <= trig_s2_r;
      conn_s1_r <= emu_connected;
      conn_s2_r <= conn_s1_r;
    end
  end

  // Control fields
  wire en = ctrl_r[CTRL_EN];
  wire dest_t dest = dest_t'(ctrl_r[CTRL_DEST +: 2]);
  wire ram_mode_t rmode = ram_mode_t'(ctrl_r[CTRL_RMODE +: 2]);
  wire rt_mode = ctrl_r[CTRL_RT];
  wire lpd_active = en && dest == DEST_LPD;

  // APB decode
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready_r && pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_tcfg = paddr == OFF_TCFG;
  wire hit_tw0 = paddr == OFF_TW0;
  wire hit_tw1 = paddr == OFF_TW1;
  wire hit_stat = paddr == OFF_STAT;
  wire hit_ist = paddr == OFF_IRQ_STAT;
  wire hit_imask = paddr == OFF_IRQ_MASK;
  wire hit_ridx = paddr == OFF_RAM_IDX;
  wire hit_rpc = paddr == OFF_RAM_PC;
  wire hit_rval = paddr == OFF_RAM_VAL;
  wire hit_rinfo = paddr == OFF_RAM_INFO;
  wire map_ok = hit_ctrl | hit_tcfg | hit_tw0 | hit_tw1 | hit_stat | hit_ist
    | hit_imask | hit_ridx | hit_rpc | hit_rval | hit_rinfo;
  wire trace_rec_t ram_rd = ram_mem[ram_idx_r];
  wire [31:0] stat_w = {16'h0, 2'h0, ram_wp_r, ram_wrap_r, ram_stop_r,
    conn_s2_r, 1'b0, cnt_r};
  wire [31:0] rd_mux =
    hit_ctrl ? {24'h0, ctrl_r} :
    hit_tcfg ? {20'h0, tcfg_r} :
    hit_tw0 ? {16'h0, tw_r[0]} :
    hit_tw1 ? {16'h0, tw_r[1]} :
    hit_stat ? stat_w :
    hit_ist ? {26'h0, irq_stat_r} :
    hit_imask ? {26'h0, irq_mask_r} :
    hit_ridx ? {26'h0, ram_idx_r} :
    hit_rpc ? ram_rd.pc :
    hit_rval ? ram_rd.val :
    hit_rinfo ? {24'h0, ram_rd.kind, ram_rd.pc_ok, ram_rd.num} : 32'h0;
  wire restart = wr_en && hit_ctrl && pwdata[CTRL_RESTART];

  // No wait states: data captured in setup, pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !map_ok;
      if (setup)
        prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      tcfg_r <= TCFG_RST;
      tw_r[0] <= TW_RST;
      tw_r[1] <= TW_RST;
      irq_mask_r <= '0;
      ram_idx_r <= 6'h00;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_r <= pwdata[7:0];
      if (hit_tcfg) tcfg_r <= pwdata[11:0];
      if (hit_tw0) tw_r[0] <= pwdata[15:0];
      if (hit_tw1) tw_r[1] <= pwdata[15:0];
      if (hit_imask) irq_mask_r <= pwdata[IRQ_W-1:0];
      if (hit_ridx) ram_idx_r <= pwdata[5:0];
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  wire [IRQ_W-1:0] irq_clr = (wr_en && hit_ist) ? pwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Instruction sequencer
  wire accept = instr_valid && ready_r;
  wire bad_range = instr.op == OP_REG
    && instr.first_trace_reg > instr.last_trace_reg;
  wire start = accept && conn_s2_r && en && !bad_range;
  wire space_ok = rt_mode || cnt_r < BUF_DATA_MAX;
  wire emit = state_r == SEQ_EMIT && space_ok;
  wire more = cur_r.op == OP_REG && idx_r != cur_r.last_trace_reg;
  wire put_pc = cur_r.op == OP_PC || cur_r.with_pc;
  trace_rec_t rec;
  assign rec.kind = cur_r.op == OP_PC ? REC_PC :
    cur_r.op == OP_TAG ? REC_TAG : REC_REG;
  assign rec.pc_ok = put_pc;
  assign rec.num = cur_r.op == OP_REG ? idx_r : 5'h00;
  assign rec.pc = put_pc ? cur_r.pc : 32'h0;
  assign rec.val = cur_r.op == OP_TAG ? {22'h0, cur_r.tag_immediate} :
    cur_r.op == OP_REG ? gpr_val : 32'h0;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SEQ_IDLE: if (start) state_nxt = SEQ_EMIT;
      SEQ_EMIT: if (emit && !more) state_nxt = SEQ_IDLE;
      default: state_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SEQ_IDLE;
      cur_r <= '0;
      idx_r <= 5'h00;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= state_nxt == SEQ_IDLE;
      if (start) begin
        cur_r <= instr;
        idx_r <= instr.first_trace_reg;
      end else if (emit && more) begin
        idx_r <= idx_r + 5'h01;
      end
    end
  end

  // Eight-stage buffer; stage eight only ever takes the overflow marker
  wire drain_ok = dest == DEST_RAM || !rec_valid_r || rec_ready;
  wire pop = cnt_r != 4'h0 && drain_ok;
  wire buf_wr = emit && cnt_r < BUF_DEPTH;
  wire ovf = emit && cnt_r == BUF_DATA_MAX;
  trace_rec_t ovf_rec;
  assign ovf_rec = '{kind: REC_OVF, pc_ok: 1'b0, num: 5'h00, pc: 32'h0,
    val: 32'h0};
  wire [3:0] cnt_nxt = cnt_r + {3'h0, buf_wr} - {3'h0, pop};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= 3'h0;
      rp_r <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
      if (buf_wr)
        wp_r <= wp_r + 3'h1;
      if (pop)
        rp_r <= rp_r + 3'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (buf_wr)
      buf_mem[wp_r] <= ovf ? ovf_rec : rec;
  end

  // Routing to trace memory or the outbound record port
  wire ram_we = pop && dest == DEST_RAM && !ram_stop_r;
  wire ram_end = ram_we && ram_wp_r == RAM_LAST;
  wire full_brk = ram_end && rmode == RM_BREAK;
  wire trig_halt = |trig_stop;

  always_ff @(posedge pclk) begin
    if (ram_we)
      ram_mem[ram_wp_r] <= buf_mem[rp_r];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_wp_r <= 6'h00;
      ram_stop_r <= 1'b0;
      ram_wrap_r <= 1'b0;
    end else if (restart) begin
      ram_wp_r <= 6'h00;
      ram_stop_r <= 1'b0;
      ram_wrap_r <= 1'b0;
    end else begin
      if (ram_we)
        ram_wp_r <= ram_wp_r + 6'h01;
      if (ram_end && rmode == RM_RING)
        ram_wrap_r <= 1'b1;
      if ((ram_end && rmode != RM_RING) || trig_halt)
        ram_stop_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_valid_r <= 1'b0;
      rec_data_r <= '0;
      rec_dest_r <= DEST_EXT;
    end else if (pop && dest != DEST_RAM) begin
      rec_valid_r <= 1'b1;
      rec_data_r <= buf_mem[rp_r];
      rec_dest_r <= dest;
    end else if (rec_ready) begin
      rec_valid_r <= 1'b0;
    end
  end

  // Trigger inputs and outputs, one slice per channel
  wire brk_any = |trig_brk || full_brk || cpu_break;
  genvar c;
  generate
    for (c = 0; c < TRIG_CH; c++) begin : g_ch
      wire s = trig_s2_r[c];
      wire p = trig_prev_r[c];
      wire cond_t cond = cond_t'(tcfg_r[c*TCFG_STRIDE +: 3]);
      wire act_stop = ctrl_r[CTRL_ACT0 + c];
      wire oen = tcfg_r[TCFG_OEN0 + c*TCFG_OSTRIDE];
      wire pol = tcfg_r[TCFG_POL0 + c*TCFG_OSTRIDE];
      wire [15:0] width = tw_r[c] == 16'h0 ? TW_RST : tw_r[c];
      logic busy_r, out_r;
      logic [7:0] presc_r;
      logic [15:0] left_r;
      assign trig_det[c] = cond == C_RISE ? (s && !p) :
        cond == C_FALL ? (!s && p) :
        cond == C_BOTH ? (s != p) :
        cond == C_LOW ? !s :
        cond == C_HIGH ? s : 1'b0;
      assign trig_brk[c] = trig_det[c] && (lpd_active || !act_stop);
      assign trig_stop[c] = trig_det[c] && !lpd_active && act_stop;
      assign trig_out_w[c] = out_r;
      wire tick = presc_r == CYC_PER_US - 8'h01;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          busy_r <= 1'b0;
          out_r <= 1'b1;
          presc_r <= 8'h00;
          left_r <= 16'h0000;
        end else begin
          out_r <= busy_r ? pol : !pol;
          if (brk_any && oen && !busy_r) begin
            busy_r <= 1'b1;
            presc_r <= 8'h00;
            left_r <= width;
          end else if (busy_r) begin
            presc_r <= tick ? 8'h00 : presc_r + 8'h01;
            if (tick) begin
              left_r <= left_r - 16'h0001;
              if (left_r == 16'h0001)
                busy_r <= 1'b0;
            end
          end
        end
      end
      chk_pulse_start: assert property (@(posedge pclk) disable iff (!presetn)
        brk_any && oen && !busy_r |=> ##1 out_r == pol)
        else $error("trigger pulse did not start");
      chk_pulse_hold: assert property (@(posedge pclk) disable iff (!presetn)
        busy_r && left_r > 16'h0001 |=> busy_r [*8])
        else $error("trigger pulse ended early");
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      break_r <= 1'b0;
    else
      break_r <= brk_any;
  end

  assign irq_ev[IRQ_OVF] = ovf;
  assign irq_ev[IRQ_TRIG0 +: TRIG_CH] = trig_det;
  assign irq_ev[IRQ_FULL] = ram_end;
  assign irq_ev[IRQ_RANGE] = accept && bad_range;
  assign irq_ev[IRQ_BRK] = brk_any;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign instr_ready = ready_r;
  assign gpr_idx = idx_r;
  assign trig_out = trig_out_w;
  assign break_req = break_r;
  assign rec_valid = rec_valid_r;
  assign rec_data = rec_data_r;
  assign rec_dest = rec_dest_r;
  assign irq = irq_r;

  chk_buf_bound: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_r <= BUF_DEPTH)
    else $error("trace buffer count past eight");
  chk_ovf_marker: assert property (@(posedge pclk) disable iff (!presetn)
    ovf |=> buf_mem[$past(wp_r)].kind == REC_OVF)
    else $error("overflow marker missing in stage eight");
  chk_one_stage: assert property (@(posedge pclk) disable iff (!presetn)
    emit && cnt_r < BUF_DATA_MAX && !pop |=> cnt_r == $past(cnt_r) + 4'h1)
    else $error("record did not take one stage");
  chk_no_emu: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !conn_s2_r |=> state_r == SEQ_IDLE && !emit)
    else $error("trace emitted without emulator");
  chk_pc_record: assert property (@(posedge pclk) disable iff (!presetn)
    emit && cur_r.op == OP_PC |-> rec.pc == cur_r.pc && rec.pc_ok)
    else $error("pc record lacks current pc");
  chk_tag_value: assert property (@(posedge pclk) disable iff (!presetn)
    emit && cur_r.op == OP_TAG |-> rec.val[9:0] == cur_r.tag_immediate)
    else $error("tag record lacks immediate");
  chk_reg_ascend: assert property (@(posedge pclk) disable iff (!presetn)
    emit && more |=> idx_r == $past(idx_r) + 5'h01 && gpr_idx == idx_r)
    else $error("register walk not ascending");
  chk_lpd_break: assert property (@(posedge pclk) disable iff (!presetn)
    lpd_active && |trig_det |=> break_req && !$rose(ram_stop_r))
    else $error("trigger on link did more than break");
  chk_trig_stop: assert property (@(posedge pclk) disable iff (!presetn)
    |trig_stop && !restart |=> ram_stop_r)
    else $error("trigger did not stop recording");
  chk_route_out: assert property (@(posedge pclk) disable iff (!presetn)
    pop && dest != DEST_RAM |=> rec_valid && rec_dest == $past(dest))
    else $error("record not routed to port");
  chk_ring_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    ram_end && rmode == RM_RING && !restart && !trig_halt
    |=> ram_wp_r == 6'h00 && !ram_stop_r)
    else $error("ring mode did not wrap");
endmodule

// file: sw_trace_pkg.sv
// Constants, types and register map of the software trace and trigger unit.
// Assumes one 200 MHz clock and an APB master with 32-bit data.
package sw_trace_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PULSE_STEP_US = 1;
  localparam logic [7:0] CYC_PER_US = 8'(PULSE_STEP_US * 1000000 / CLK_PERIOD_PS);
  localparam int TRIG_CH = 2;
  localparam logic [3:0] BUF_DEPTH = 4'h8;
  localparam logic [3:0] BUF_DATA_MAX = 4'h7;
  localparam int RAM_DEPTH = 64;
  localparam logic [5:0] RAM_LAST = 6'h3f;
  // APB byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_TCFG = 12'h004;
  localparam logic [11:0] OFF_TW0 = 12'h008;
  localparam logic [11:0] OFF_TW1 = 12'h00c;
  localparam logic [11:0] OFF_STAT = 12'h010;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] OFF_RAM_IDX = 12'h01c;
  localparam logic [11:0] OFF_RAM_PC = 12'h020;
  localparam logic [11:0] OFF_RAM_VAL = 12'h024;
  localparam logic [11:0] OFF_RAM_INFO = 12'h028;
  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_DEST = 1;
  localparam int CTRL_RMODE = 3;
  localparam int CTRL_RT = 5;
  localparam int CTRL_ACT0 = 6;
  localparam int CTRL_RESTART = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Trigger configuration fields
  localparam int TCFG_STRIDE = 4;
  localparam int TCFG_OEN0 = 8;
  localparam int TCFG_POL0 = 9;
  localparam int TCFG_OSTRIDE = 2;
  localparam logic [11:0] TCFG_RST = 12'h000;
  localparam logic [15:0] TW_RST = 16'h0001;
  // Interrupt status bits
  localparam int IRQ_OVF = 0;
  localparam int IRQ_TRIG0 = 1;
  localparam int IRQ_FULL = 3;
  localparam int IRQ_RANGE = 4;
  localparam int IRQ_BRK = 5;
  localparam int IRQ_W = 6;

  typedef enum logic [1:0] {OP_PC, OP_TAG, OP_REG} op_t;
  typedef enum logic [1:0] {REC_PC, REC_TAG, REC_REG, REC_OVF} rec_kind_t;
  typedef enum logic [1:0] {DEST_RAM, DEST_EXT, DEST_LPD} dest_t;
  typedef enum logic [1:0] {RM_STOP, RM_BREAK, RM_RING} ram_mode_t;
  typedef enum logic [2:0] {C_RISE, C_FALL, C_BOTH, C_LOW, C_HIGH} cond_t;
  typedef enum logic {SEQ_IDLE, SEQ_EMIT} seq_t;

  typedef struct packed {
    rec_kind_t kind;
    logic pc_ok;
    logic [4:0] num;
    logic [31:0] pc;
    logic [31:0] val;
  } trace_rec_t;

  typedef struct packed {
    op_t op;
    logic with_pc;
    logic [31:0] pc;
    logic [9:0] tag_immediate;
    logic [4:0] first_trace_reg;
    logic [4:0] last_trace_reg;
  } instr_t;
endpackage

// file: emu_model.sv
// Debug emulator stand-in: connection level, trigger pins, record sink.
// Assumes the unit's record port and pclk; bench steers it by inputs.
`timescale 1ns/1ps
module emu_model import sw_trace_pkg::*; (
  input wire logic pclk,
  input wire logic conn,
  input wire logic stall,
  input wire logic slow,
  input wire logic [1:0] trig_lvl,
  output logic emu_connected,
  output logic [1:0] trig_in,
  input wire logic rec_valid,
  input wire trace_rec_t rec_data,
  input wire dest_t rec_dest,
  output logic rec_ready
);
  trace_rec_t recs[$];
  logic ph = 1'b0;
  dest_t last_dest = DEST_RAM;
  assign emu_connected = conn;
  assign trig_in = trig_lvl;
  // Slow mode takes a record only every other cycle
  assign rec_ready = !stall && (!slow || ph);
  always @(posedge pclk) begin
    ph <= ~ph;
    if (rec_valid && rec_ready) begin
      recs.push_back(rec_data);
      last_dest <= rec_dest;
    end
  end
endmodule

// file: soft_trace_and_trigger_unit_tb.sv
// Self-checking bench for the software trace and trigger unit.
// Assumes emu_model on the far side and APB access to the registers.
`timescale 1ns/1ps
module soft_trace_and_trigger_unit_tb import sw_trace_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, gpr_val, rd;
  logic pready, pslverr, instr_ready, emu_connected, break_req;
  logic rec_valid, rec_ready, irq, e;
  instr_t instr = '0;
  logic instr_valid = 1'b0;
  logic cpu_break = 1'b0;
  logic [4:0] gpr_idx;
  logic [1:0] trig_in, trig_out;
  trace_rec_t rec_data, r;
  dest_t rec_dest;
  logic conn = 1'b1;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [1:0] trig_lvl = 2'b00;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int brk_n = 0;
  int n0, d;

  soft_trace_and_trigger_unit dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .gpr_idx(gpr_idx), .gpr_val(gpr_val), .cpu_break(cpu_break),
    .emu_connected(emu_connected), .trig_in(trig_in), .trig_out(trig_out),
    .break_req(break_req), .rec_valid(rec_valid), .rec_data(rec_data),
    .rec_dest(rec_dest), .rec_ready(rec_ready), .irq(irq));
  emu_model emu (.pclk(pclk), .conn(conn), .stall(stall), .slow(slow),
    .trig_lvl(trig_lvl), .emu_connected(emu_connected), .trig_in(trig_in),
    .rec_valid(rec_valid), .rec_data(rec_data), .rec_dest(rec_dest),
    .rec_ready(rec_ready));

  always #2.5 pclk = ~pclk;
  assign gpr_val = {16'ha5a5, 11'h000, gpr_idx};
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (break_req) begin
      brk_n <= brk_n + 1;
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task stop_test();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      chk(0, 1, "no pready");
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
    input string s);
    apb(1'b0, a, 32'h0);
    chk(rd & m, x, s);
  endtask

  task op(input op_t o, input logic wp, input logic [31:0] pc,
    input logic [9:0] t, input logic [4:0] f, input logic [4:0] l);
    int n;
    n = 0;
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr <= '{o, wp, pc, t, f, l};
    do begin
      @(posedge pclk);
      n++;
    end while (instr_ready !== 1'b1 && n < 50);
    instr_valid <= 1'b0;
    if (n == 50) begin
      chk(0, 1, "instr not taken");
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (instr_ready !== 1'b1 && n < 50);
    if (n == 50) begin
      chk(0, 1, "instr stuck");
    end
  endtask

  // Counts cycles a trigger output spends at lvl once the pulse starts
  task width(input int ch, input logic lvl, input int x);
    int n;
    n = 0;
    while (trig_out[ch] !== lvl && n < 30) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (trig_out[ch] === lvl && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(n, x, "pulse width");
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(OFF_CTRL, 32'hff, 32'h0, "ctrl reset");
    rdc(OFF_TCFG, 32'hfff, 32'h0, "tcfg reset");
    rdc(OFF_TW1, 32'hffff, 32'h1, "width reset");
    rdc(12'h0fc, 32'hffffffff, 32'h0, "unmapped read");
    chk(e, 1, "unmapped error");
    $display("test reset done");
    wr(OFF_CTRL, 32'h101);
    op(OP_PC, 1'b0, 32'h1234, 10'h0, 5'd0, 5'd0);
    wr(OFF_RAM_IDX, 32'h0);
    rdc(OFF_RAM_PC, 32'hffffffff, 32'h1234, "pc record");
    rdc(OFF_RAM_INFO, 32'hff, 32'h20, "pc info");
    rdc(OFF_STAT, 32'h3f20, 32'h0120, "ram pointer");
    @(posedge pclk);
    conn <= 1'b0;
    wr(OFF_CTRL, 32'h101);
    op(OP_PC, 1'b0, 32'h1238, 10'h0, 5'd0, 5'd0);
    rdc(OFF_STAT, 32'h3f20, 32'h0, "no emulator");
    conn <= 1'b1;
    slow <= 1'b1;
    $display("test memory done");
    wr(OFF_CTRL, 32'h3);
    op(OP_TAG, 1'b1, 32'h2000, 10'h3ff, 5'd0, 5'd0);
    op(OP_TAG, 1'b0, 32'h2004, 10'h155, 5'd0, 5'd0);
    op(OP_REG, 1'b1, 32'h2008, 10'h0, 5'd3, 5'd5);
    op(OP_REG, 1'b0, 32'h200c, 10'h0, 5'd6, 5'd2);
    repeat (20) @(posedge pclk);
    chk(emu.recs.size(), 5, "record count");
    r = emu.recs[0];
    chk({r.kind, r.pc_ok, r.pc[15:0], r.val[9:0]}, {REC_TAG, 1'b1,
      16'h2000, 10'h3ff}, "tag with pc");
    r = emu.recs[1];
    chk({r.kind, r.pc_ok, r.val}, {REC_TAG, 1'b0, 32'h155}, "tag");
    for (int i = 0; i < 3; i++) begin
      r = emu.recs[2 + i];
      chk({r.kind, r.num, r.val}, {REC_REG, 5'(3 + i), 16'ha5a5, 11'h0,
        5'(3 + i)}, "register record");
    end
    rdc(OFF_IRQ_STAT, 32'h10, 32'h10, "bad range");
    chk(emu.last_dest, DEST_EXT, "record route");
    $display("test stream done");
    @(posedge pclk);
    slow <= 1'b0;
    stall <= 1'b1;
    wr(OFF_CTRL, 32'h23);
    emu.recs.delete();
    for (int i = 0; i < 10; i++) begin
      op(OP_PC, 1'b0, 32'(i), 10'h0, 5'd0, 5'd0);
    end
    rdc(OFF_STAT, 32'hf, 32'h8, "buffer full");
    rdc(OFF_IRQ_STAT, 32'h1, 32'h1, "overflow flag");
    stall <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(emu.recs[0].pc, 32'h0, "first kept");
    chk(emu.recs[$].kind, REC_OVF, "overflow marker");
    chk(emu.recs.size(), 9, "kept count");
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CTRL, 32'h101 | (32'(m) << 3));
      n0 = brk_n;
      for (int i = 0; i < 65; i++) begin
        op(OP_PC, 1'b0, 32'(i), 10'h0, 5'd0, 5'd0);
      end
      rdc(OFF_STAT, 32'hc0, m == 2 ? 32'h80 : 32'h40, "memory mode");
      chk(brk_n - n0, 32'(m == 1), "full break");
    end
    wr(OFF_RAM_IDX, 32'h0);
    rdc(OFF_RAM_PC, 32'hffffffff, 32'd64, "ring overwrite");
    $display("test buffer done");
    wr(OFF_CTRL, 32'h101);
    wr(OFF_TCFG, 32'h700);
    wr(OFF_TW0, 32'h2);
    wr(OFF_IRQ_STAT, 32'h3f);
    chk(trig_out, 2'b10, "idle levels");
    trig_lvl[0] <= 1'b1;
    width(0, 1'b1, 400);
    chk(trig_out, 2'b10, "idle after pulse");
    rdc(OFF_IRQ_STAT, 32'h22, 32'h22, "trigger flags");
    // Same edge with the stop action: recording stops, no pulse
    wr(OFF_CTRL, 32'h41);
    trig_lvl[0] <= 1'b0;
    repeat (8) @(posedge pclk);
    trig_lvl[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(trig_out, 2'b10, "no pulse on stop");
    trig_lvl[0] <= 1'b0;
    rdc(OFF_STAT, 32'h40, 32'h40, "trigger stop");
    wr(OFF_IRQ_MASK, 32'h2);
    op(OP_REG, 1'b0, 32'h0, 10'h0, 5'd6, 5'd2);
    chk(irq, 1, "irq raised");
    wr(OFF_IRQ_STAT, 32'h3f);
    repeat (2) @(posedge pclk);
    chk(irq, 0, "irq cleared");
    cpu_break <= 1'b1;
    @(posedge pclk);
    cpu_break <= 1'b0;
    width(1, 1'b0, 200);
    repeat (300) @(posedge pclk);
    wr(OFF_CTRL, 32'h145);
    n0 = brk_n;
    trig_lvl[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    trig_lvl[0] <= 1'b0;
    chk(brk_n - n0, 1, "lpd break");
    rdc(OFF_STAT, 32'h40, 32'h0, "lpd no stop");
    repeat (450) @(posedge pclk);
    for (int c = 0; c < 5; c++) begin
      trig_lvl[1] <= (c == 1 || c == 3);
      repeat (8) @(posedge pclk);
      wr(OFF_TCFG, 32'(c) << 4);
      repeat (8) @(posedge pclk);
      n0 = brk_n;
      repeat (10) @(posedge pclk);
      chk(brk_n - n0, 0, "quiet condition");
      trig_lvl[1] <= !(c == 1 || c == 3);
      n0 = brk_n;
      repeat (12) @(posedge pclk);
      d = brk_n - n0;
      chk(32'(c < 3 ? d == 1 : d > 1), 1, "condition fires");
    end
    $display("test trigger done");
    stop_test();
  end
endmodule
